// ==== rtl/stream_to_memory_channel_status_regs.vh ====
/*
  Offsets, field positions, reset values and timing counts for the
  stream-to-memory channel status block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef STREAM_TO_MEMORY_CHANNEL_STATUS_REGS_VH
`define STREAM_TO_MEMORY_CHANNEL_STATUS_REGS_VH

// register byte offsets
`define OFF_CTRL        8'h30
`define OFF_STATUS      8'h34
`define OFF_LENGTH      8'h58
`define OFF_TAIL        8'h48
`define OFF_IRQ_STATUS  8'h60
`define OFF_IRQ_MASK    8'h64

// status fields
`define ST_HALTED       0
`define ST_IDLE         1
`define ST_RSVD         2
`define ST_SG_INCLD     3
`define ST_INT_ERR      4

// control fields
`define CTRL_RUN_STOP   0

// interrupt event bits
`define EV_HALTED       0
`define EV_IDLE         1
`define EV_INT_ERR      2
`define EV_WIDTH        3

// reset values
`define RST_HALTED      1'b1
`define RST_IDLE        1'b0
`define RST_LENGTH      26'h0000000

// timing: drain lag after run/stop clears, in ns and in cycles at 50 ns
`define DRAIN_TIME_NS   200
`define CLK_PERIOD_NS   50
// 200 ns at 50 ns is four cycles; sized to match the 3-bit drain counter
`define DRAIN_CYCLES    3'h4

`endif

// ==== rtl/stream_to_memory_channel_status.v ====
/*
  Stream-to-memory channel control/status core: run/stop control, halted and
  idle tracking, internal error detection with graceful halt, and a sticky
  interrupt status with mask.
  Assumes a single 20 MHz clock, synchronous inputs, and a simple register port
  (address, write data, write strobe, read strobe, read data one cycle later).
*/
// Summary of operation
// - bit 0 shows halted; reads 1 after reset
// - sg: halt after run/stop low, engines quiet
// - direct: halt after run/stop low, mover quiet
// - halt lags run/stop; software polls
// - halted sg ignores tail pointer writes
// - sg idle when tail reached, all done
// - direct idle once current transfer done
// - idle reads 0 while halted
// - direct idle 0 until first transfer
// - bit 2 reserved, reads zero
// - bit 3 mirrors descriptor engine build option
// - sg: error on zero-length fetched descriptor
// - sg: error on received length field mismatch
// - direct: error on memory write fault
// - direct: error when packet exceeds length
// - error clears run/stop, halts when drained
`include "stream_to_memory_channel_status_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module stream_to_memory_channel_status #(
  parameter       descriptor_engine_build_option = 1
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  output reg         irq_out,
  // datapath activity and events from the mover and descriptor engine
  input  wire        mover_busy_in,
  input  wire        fetch_busy_in,
  input  wire        xfer_done_in,
  input  wire        sg_tail_reached_in,
  input  wire        sg_queue_empty_in,
  input  wire        desc_fetched_in,
  input  wire [25:0] desc_len_in,
  input  wire        stat_len_valid_in,
  input  wire [25:0] received_length_field_in,
  input  wire [25:0] stream_pkt_bytes_in,
  input  wire        mem_write_err_in,
  input  wire        pkt_end_in,
  input  wire [25:0] pkt_bytes_in,
  output reg         start_sg_out,
  output reg         start_direct_out,
  output reg  [25:0] xfer_len_out,
  output reg         run_stop_out
);

  // build option folded to one bit; the block is specialised at
  // elaboration, so the unused mode's error sources cost no logic.
  // limitation: run/stop is the only control bit handled here; the
  // remaining control fields live with the rest of the channel
  localparam SG = (descriptor_engine_build_option != 0);

  // channel states, one-hot:
  //   halted - run/stop low or just restarted; no starts accepted
  //   run    - engines may move data or fetch descriptors
  //   drain  - run/stop dropped or error seen; wait for engines to go
  //            quiet and for the drain count to expire before halting
  //   idle   - running with nothing queued; a new pointer or length
  //            write moves back to run
  localparam [3:0] S_HALTED  = 4'h1;
  localparam [3:0] S_RUN     = 4'h2;
  localparam [3:0] S_DRAIN   = 4'h4;
  localparam [3:0] S_IDLE    = 4'h8;

  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg        run_stop_r;
  reg        halted_r;
  reg        idle_r;
  reg        int_err_r;
  reg        first_done_r;
  reg [2:0]  drain_cnt_r;
  reg [`EV_WIDTH-1:0] irq_stat_r;
  reg [`EV_WIDTH-1:0] irq_mask_r;
  reg        err_evt;
  reg        engines_quiet;
  reg [31:0] status_word;
  reg        halted_prev_r;
  reg        idle_prev_r;

  // register decode, shared by read and write paths
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // read mux; unmapped addresses read zero
  function [31:0] read_word;
    input [7:0]           a;
    input [31:0]          st;
    input                 rs;
    input [25:0]          len;
    input [`EV_WIDTH-1:0] ist;
    input [`EV_WIDTH-1:0] imk;
    begin
      if (hit(a, `OFF_STATUS))
        read_word = st;
      else if (hit(a, `OFF_CTRL))
        read_word = {31'h00000000, rs};
      else if (hit(a, `OFF_LENGTH))
        read_word = {6'h00, len};
      else if (hit(a, `OFF_IRQ_STATUS))
        read_word = {29'h00000000, ist};
      else if (hit(a, `OFF_IRQ_MASK))
        read_word = {29'h00000000, imk};
      else
        read_word = 32'h00000000;
    end
  endfunction

  // write decodes, one per writable register except tail (decoded inline), so every process sees the same hit;
  // keeps the flag processes short and their priorities easy to read
  wire                 wr_ctrl;
  wire                 wr_len;
  wire                 wr_irq_stat;
  wire                 wr_irq_mask;
  wire [`EV_WIDTH-1:0] w1c_bits;
  wire [`EV_WIDTH-1:0] ev_bits;

  // strobes qualified by address
  assign wr_ctrl     = wr_in && hit(addr_in, `OFF_CTRL);
  assign wr_len      = wr_in && hit(addr_in, `OFF_LENGTH);
  assign wr_irq_stat = wr_in && hit(addr_in, `OFF_IRQ_STATUS);
  assign wr_irq_mask = wr_in && hit(addr_in, `OFF_IRQ_MASK);
  assign w1c_bits    = wr_irq_stat ? wdata_in[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

  // error sources; checks gated by mode since sources differ per build.
  // a source that fires while halted is ignored further down, so a
  // stray pulse after shutdown cannot re-arm the error flag
  always @* begin
    err_evt = 1'b0;
    if (SG) begin
      if (desc_fetched_in && desc_len_in == 26'h0000000)
        err_evt = 1'b1;
      if (stat_len_valid_in && received_length_field_in != stream_pkt_bytes_in)
        err_evt = 1'b1;
    end else begin
      if (mem_write_err_in)
        err_evt = 1'b1;
      if (pkt_end_in && pkt_bytes_in > xfer_len_out)
        err_evt = 1'b1;
    end
  end

  // quiet means no data movement and, with sg, no fetch activity
  always @* begin
    if (SG)
      engines_quiet = !mover_busy_in && !fetch_busy_in;
    else
      engines_quiet = !mover_busy_in;
  end

  // channel state machine; a fresh error in run or idle heads straight
  // to drain, so software cannot hold the channel running past it
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_HALTED: begin
        if (run_stop_r && !int_err_r)
          state_nxt = S_RUN;
      end
      S_RUN: begin
        if (!run_stop_r || err_evt)
          state_nxt = S_DRAIN;
        else if (SG && sg_tail_reached_in && sg_queue_empty_in)
          state_nxt = S_IDLE;
        else if (!SG && xfer_done_in)
          state_nxt = S_IDLE;
      end
      S_IDLE: begin
        if (!run_stop_r || err_evt)
          state_nxt = S_DRAIN;
        else if (wr_in && SG && hit(addr_in, `OFF_TAIL))
          state_nxt = S_RUN;
        else if (wr_in && !SG && hit(addr_in, `OFF_LENGTH))
          state_nxt = S_RUN;
      end
      S_DRAIN: begin
        // lag between run/stop low and halted gives engines time to flush
        if (engines_quiet && drain_cnt_r == 3'h0)
          state_nxt = S_HALTED;
      end
      default: state_nxt = S_HALTED;
    endcase
  end

  // state register
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= S_HALTED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // run/stop; error wins over a software set in the same cycle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_stop_r <= 1'b0;
    end else if (err_evt && !halted_r) begin
      run_stop_r <= 1'b0;
    end else if (wr_ctrl) begin
      run_stop_r <= wdata_in[`CTRL_RUN_STOP];
    end
  end

  // internal error, sticky until software restarts a halted channel;
  // clearing only while halted keeps a live fault from being masked
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_err_r <= 1'b0;
    end else if (err_evt && !halted_r) begin
      int_err_r <= 1'b1;
    end else if (wr_ctrl && wdata_in[`CTRL_RUN_STOP] && halted_r) begin
      int_err_r <= 1'b0;
    end
  end

  // drain counter, loaded on entry to the drain state
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drain_cnt_r <= 3'h0;
    end else if (state_r != S_DRAIN && state_nxt == S_DRAIN) begin
      drain_cnt_r <= `DRAIN_CYCLES;
    end else if (drain_cnt_r != 3'h0) begin
      drain_cnt_r <= drain_cnt_r - 3'h1;
    end
  end

  // halted follows the next state, so it moves on the same edge as the fsm
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      halted_r <= `RST_HALTED;
    end else begin
      halted_r <= (state_nxt == S_HALTED);
    end
  end

  // first completed direct transfer, never cleared until reset
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_done_r <= 1'b0;
    end else if (!SG && state_r == S_RUN && xfer_done_in) begin
      first_done_r <= 1'b1;
    end
  end

  // idle only when not halted, and in direct mode after first transfer;
  // done pulse counted directly so idle is not a cycle late the first time
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_r <= `RST_IDLE;
    end else begin
      idle_r <= (state_nxt == S_IDLE) && (SG || first_done_r || xfer_done_in);
    end
  end

  // length accepted whenever not halted, drain included; halted ignores it
  // in either mode, so a length written after halt cannot be picked up later
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xfer_len_out <= `RST_LENGTH;
    end else if (wr_len && !halted_r) begin
      xfer_len_out <= wdata_in[25:0];
    end
  end

  // tail write starts the descriptor engine only while running;
  // a halted channel ignores it so stale pointers cannot kick off work
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_sg_out <= 1'b0;
    end else begin
      start_sg_out <= SG && wr_in && hit(addr_in, `OFF_TAIL) && run_stop_r && !halted_r;
    end
  end

  // length write starts a direct transfer only while running
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_direct_out <= 1'b0;
    end else begin
      start_direct_out <= !SG && wr_len && run_stop_r && !halted_r;
    end
  end

  // registered copy of run/stop for the datapath
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_stop_out <= 1'b0;
    end else begin
      run_stop_out <= run_stop_r;
    end
  end

  // status word assembly; no write path reaches bits 0..4
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_HALTED]   = halted_r;
    status_word[`ST_IDLE]     = idle_r && !halted_r;
    status_word[`ST_RSVD]     = 1'b0;
    status_word[`ST_SG_INCLD] = SG;
    status_word[`ST_INT_ERR]  = int_err_r;
  end

  // event pulses: halted rise, idle rise, newly seen error
  assign ev_bits = {err_evt && !halted_r, idle_r && !idle_prev_r, halted_r && !halted_prev_r};

  // edge history; reset matches the flags so no false edge follows reset
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      halted_prev_r <= `RST_HALTED;
      idle_prev_r   <= `RST_IDLE;
    end else begin
      halted_prev_r <= halted_r;
      idle_prev_r   <= idle_r;
    end
  end

  // interrupt mask
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= {`EV_WIDTH{1'b0}};
    end else if (wr_irq_mask) begin
      irq_mask_r <= wdata_in[`EV_WIDTH-1:0];
    end
  end

  // sticky interrupt status: set wins over write-one-to-clear
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= {`EV_WIDTH{1'b0}};
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c_bits) | ev_bits;
    end
  end

  // level interrupt, registered so the pin comes straight from a flop
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read data, one cycle after the strobe; zero otherwise so a stale word never lingers
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      rdata_out <= read_word(addr_in, status_word, run_stop_r, xfer_len_out, irq_stat_r, irq_mask_r);
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/stream_to_memory_channel_status_props.sv ====
/* status block port checker.
   assumes bind onto stream_to_memory_channel_status, single clock, async low reset */
`timescale 1ns/1ps
`default_nettype none
module stream_to_memory_channel_status_chk #(parameter descriptor_engine_build_option = 1) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        desc_fetched_in,
  input wire logic [25:0] desc_len_in,
  input wire logic        stat_len_valid_in,
  input wire logic [25:0] received_length_field_in,
  input wire logic [25:0] stream_pkt_bytes_in,
  input wire logic        start_sg_out,
  input wire logic        run_stop_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic ran_r;
  wire  st_rd = rd_in && addr_in == 8'h34;
  wire  go_wr = wr_in && addr_in == 8'h30 && wdata_in[0];
  // halted may only drop once software has asked to run
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) ran_r <= 1'b0;
    else if (go_wr) ran_r <= 1'b1;
  halt_after_reset_a: assert property (st_rd && !ran_r |=> rdata_out[0])
    else $error("halted low before first run");
  idle_when_halted_a: assert property (st_rd |=> !(rdata_out[0] && rdata_out[1]))
    else $error("idle and halted together");
  rsvd_zero_a: assert property (st_rd |=> !rdata_out[2])
    else $error("reserved bit set");
  build_flag_a: assert property (st_rd |=> rdata_out[3] == (descriptor_engine_build_option != 0))
    else $error("build flag wrong");
  halted_tail_a: assert property (wr_in && addr_in == 8'h48 && !run_stop_out |=> !start_sg_out [*2])
    else $error("start while stopped");
  zero_len_err_a: assert property (descriptor_engine_build_option != 0 && desc_fetched_in && desc_len_in == 26'h0
    && run_stop_out |-> ##[1:3] !run_stop_out)
    else $error("zero length did not stop");
  len_mismatch_a: assert property (descriptor_engine_build_option != 0 && stat_len_valid_in
    && received_length_field_in != stream_pkt_bytes_in && run_stop_out |-> ##[1:3] !run_stop_out)
    else $error("length mismatch did not stop");
  run_needs_write_a: assert property ($rose(run_stop_out) |-> $past(go_wr) || $past(go_wr, 2))
    else $error("run set without write");
endmodule
bind stream_to_memory_channel_status stream_to_memory_channel_status_chk #(.descriptor_engine_build_option(descriptor_engine_build_option)) chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .desc_fetched_in(desc_fetched_in), .desc_len_in(desc_len_in),
  .stat_len_valid_in(stat_len_valid_in), .received_length_field_in(received_length_field_in),
  .stream_pkt_bytes_in(stream_pkt_bytes_in), .start_sg_out(start_sg_out), .run_stop_out(run_stop_out));
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* self-checking bench for the status block, scatter/gather build.
   assumes the checker is bound separately; direct-mode inputs tied low */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_in, rst_n_in, wr_in, rd_in, mv_busy, fe_busy, tail_hit, d_fetch, len_v, irq, st_sg;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata, v;
  logic [25:0] d_len, rx_len, pk_len;
  int          miscompares = 0;
  int          checked = 0;
  stream_to_memory_channel_status uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .irq_out(irq), .mover_busy_in(mv_busy),
    .fetch_busy_in(fe_busy), .xfer_done_in(1'b0), .sg_tail_reached_in(tail_hit), .sg_queue_empty_in(tail_hit),
    .desc_fetched_in(d_fetch), .desc_len_in(d_len), .stat_len_valid_in(len_v),
    .received_length_field_in(rx_len), .stream_pkt_bytes_in(pk_len), .mem_write_err_in(1'b0),
    .pkt_end_in(1'b0), .pkt_bytes_in(26'h0), .start_sg_out(st_sg), .start_direct_out(),
    .xfer_len_out(), .run_stop_out());
  // 50 ns clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one write or read; read data lands in v
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1 v = rdata;
  endtask
  // polling, since halt lags run/stop by several cycles
  task automatic poll(input int b, input logic e);
    for (int i = 0; i < 20; i++) begin
      bus(0, 8'h34, 32'h0);
      if (v[b] === e) break;
    end
    chk(v[b], e);
  endtask
  task automatic sgo(input logic e);
    logic s;
    s = st_sg;
    repeat (3) begin
      @(posedge clk_in);
      #1 s = s | st_sg;
    end
    chk(s, e);
  endtask
  task automatic t_reset;
    bus(0, 8'h34, 32'h0);
    chk(v[4:0], 5'h09);
    bus(1, 8'h34, 32'hFFFFFFFF);
    bus(0, 8'h34, 32'h0);
    chk(v[4:0], 5'h09);
    bus(1, 8'h58, 32'h00000123);
    bus(0, 8'h58, 32'h0);
    chk(v, 32'h0);
    bus(0, 8'hFC, 32'h0);
    chk(v, 32'h0);
  endtask
  task automatic t_idle;
    bus(1, 8'h30, 32'h1);
    poll(0, 1'b0);
    bus(1, 8'h48, 32'h100);
    sgo(1'b1);
    bus(1, 8'h58, 32'hFFFFFFFF);
    bus(0, 8'h58, 32'h0);
    chk(v, 32'h03FFFFFF);
    @(posedge clk_in);
    tail_hit <= 1'b1;
    fe_busy <= 1'b0;
    poll(1, 1'b1);
    bus(1, 8'h48, 32'h140);
    sgo(1'b1);
  endtask
  task automatic t_halt;
    @(posedge clk_in);
    fe_busy <= 1'b1;
    bus(1, 8'h30, 32'h0);
    repeat (10) @(posedge clk_in);
    bus(0, 8'h34, 32'h0);
    chk(v[0], 1'b0);
    @(posedge clk_in);
    fe_busy <= 1'b0;
    poll(0, 1'b1);
    chk(v[1], 1'b0);
    bus(1, 8'h48, 32'h180);
    sgo(1'b0);
  endtask
  task automatic t_err;
    bus(1, 8'h60, 32'h7);
    bus(1, 8'h64, 32'h0);
    bus(1, 8'h30, 32'h1);
    poll(0, 1'b0);
    @(posedge clk_in);
    d_fetch <= 1'b1;
    @(posedge clk_in);
    d_fetch <= 1'b0;
    poll(0, 1'b1);
    chk(v[4], 1'b1);
    chk(irq, 1'b0);
    bus(1, 8'h64, 32'h7);
    bus(0, 8'h34, 32'h0);
    chk(irq, 1'b1);
    bus(1, 8'h60, 32'h7);
    bus(0, 8'h34, 32'h0);
    chk(irq, 1'b0);
  endtask
  task automatic t_len;
    bus(1, 8'h30, 32'h1);
    poll(0, 1'b0);
    chk(v[4], 1'b0);
    @(posedge clk_in);
    len_v <= 1'b1;
    @(posedge clk_in);
    len_v <= 1'b0;
    poll(0, 1'b1);
    chk(v[4], 1'b1);
  endtask
  // cut a hang short
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  // reset, then the scenarios in order
  initial begin
    {rst_n_in, wr_in, rd_in, mv_busy, fe_busy, tail_hit, d_fetch, len_v} = 8'h18;
    {addr_in, wdata_in, d_len} = 66'h0;
    rx_len = 26'h00000A;
    pk_len = 26'h00000C;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    mv_busy <= 1'b0;
    t_reset;
    t_idle;
    t_halt;
    t_err;
    t_len;
    close_out;
  end
endmodule
`default_nettype wire
